// File: hdl/soh_exec.sv
// executor for the set-all-ones and halt instructions, with APB registers
// assumes the fetch unit presents a word in Q4 and the register file
// takes read and write strobes one phase at a time
`timescale 1ns/10ps
`default_nettype none
module soh_exec (
	input  wire logic        clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// instruction feed
	input  wire logic        instrValid,
	input  wire logic [15:0] instrWord,
	output logic             instrTaken,
	output logic [1:0]       qPhase,
	// indexed-offset base from the core
	input  wire logic [11:0] indexBase,
	// register file port
	output logic             rfRdEn,
	output logic             rfWrEn,
	output logic [11:0]      rfAddr,
	output logic [7:0]       rfWrData,
	// watchdog and wake-up
	output logic             wdtCntClr,
	output logic [7:0]       wdtLoadValue,
	output logic             wdtPostClr,
	input  wire logic        wdtWake,
	input  wire logic        extWake,
	// power state and interrupt
	output logic             haltState,
	output logic             oscStop,
	output logic             timeout_flag_n,
	output logic             power_down_flag_n,
	output logic             irq
);

	// ----------------------------------------------------------------
	// reset synchroniser
	// ----------------------------------------------------------------
	logic rstMeta_r;
	logic rstSync_r;

	// release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// ----------------------------------------------------------------
	// decoder
	// ----------------------------------------------------------------
	soh_dec_if decBus ();

	soh_decode uDecode (
		.d (decBus.dec)
	);

	// ----------------------------------------------------------------
	// execution state
	// ----------------------------------------------------------------
	soh_pkg::soh_phase_type phase_r, phase_nxt;
	logic        iValid_r, iValid_nxt;
	logic [15:0] iWord_r, iWord_nxt;
	logic        halt_r, halt_nxt;
	logic        tmoFlag_r, tmoFlag_nxt;
	logic        pdnFlag_r, pdnFlag_nxt;
	logic        rdEn_r, rdEn_nxt;
	logic        wrEn_r, wrEn_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic        wdtClr_r, wdtClr_nxt;
	logic        taken_r, taken_nxt;
	logic [soh_pkg::EV_COUNT-1:0] evPulse;

	// apb-owned control read by the core
	logic        ext_r;
	logic [3:0]  bank_r;

	assign decBus.instrValid = iValid_r;
	assign decBus.instrWord  = iWord_r;
	assign decBus.bankSel    = bank_r;
	assign decBus.extEnable  = ext_r;
	assign decBus.indexBase  = indexBase;

	// phase walk, fetch latch, strobes and power state
	always_comb
	begin
		phase_nxt  = phase_r;
		iValid_nxt = iValid_r;
		iWord_nxt  = iWord_r;
		halt_nxt   = halt_r;
		tmoFlag_nxt = tmoFlag_r;
		pdnFlag_nxt = pdnFlag_r;
		addr_nxt   = addr_r;
		rdEn_nxt   = 1'b0;
		wrEn_nxt   = 1'b0;
		wdtClr_nxt = 1'b0;
		taken_nxt  = 1'b0;
		evPulse    = '0;
		if (halt_r)
		begin
			// clock is stopped: phase frozen in Q4 until a wake
			if (wdtWake || extWake)
			begin
				halt_nxt  = 1'b0;
				phase_nxt = soh_pkg::PH_Q1;
				iValid_nxt = 1'b0;
				evPulse[soh_pkg::EV_WAKE_BIT] = 1'b1;
				if (wdtWake)
				begin
					tmoFlag_nxt = 1'b0;
					evPulse[soh_pkg::EV_WDTW_BIT] = 1'b1;
				end
			end
		end
		else
		begin
			case (phase_r)
				soh_pkg::PH_Q1:
				begin
					phase_nxt = soh_pkg::PH_Q2;
					if (decBus.isOnes)
					begin
						rdEn_nxt = 1'b1;
						addr_nxt = decBus.effAddr;
					end
				end
				soh_pkg::PH_Q2:
				begin
					phase_nxt = soh_pkg::PH_Q3;
				end
				soh_pkg::PH_Q3:
				begin
					phase_nxt = soh_pkg::PH_Q4;
					if (decBus.isOnes)
					begin
						wrEn_nxt = 1'b1;
					end
					if (decBus.isHalt)
					begin
						halt_nxt   = 1'b1;
						pdnFlag_nxt = 1'b0;
						tmoFlag_nxt = 1'b1;
						wdtClr_nxt = 1'b1;
						evPulse[soh_pkg::EV_HALT_BIT] = 1'b1;
					end
				end
				soh_pkg::PH_Q4:
				begin
					phase_nxt  = soh_pkg::PH_Q1;
					// a missing word executes as a no-operation
					iValid_nxt = instrValid;
					iWord_nxt  = instrWord;
					taken_nxt  = instrValid;
					if (wrEn_r)
					begin
						evPulse[soh_pkg::EV_ONES_BIT] = 1'b1;
					end
				end
				default:
				begin
					phase_nxt = soh_pkg::PH_Q1;
				end
			endcase
		end
	end

	// registers of the execution state
	always_ff @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			phase_r  <= soh_pkg::PH_Q4;
			iValid_r <= 1'b0;
			iWord_r  <= 16'h0000;
			halt_r   <= 1'b0;
			tmoFlag_r <= soh_pkg::TMO_RESET;
			pdnFlag_r <= soh_pkg::PDN_RESET;
			rdEn_r   <= 1'b0;
			wrEn_r   <= 1'b0;
			addr_r   <= 12'h000;
			wdtClr_r <= 1'b0;
			taken_r  <= 1'b0;
		end
		else
		begin
			phase_r  <= phase_nxt;
			iValid_r <= iValid_nxt;
			iWord_r  <= iWord_nxt;
			halt_r   <= halt_nxt;
			tmoFlag_r <= tmoFlag_nxt;
			pdnFlag_r <= pdnFlag_nxt;
			rdEn_r   <= rdEn_nxt;
			wrEn_r   <= wrEn_nxt;
			addr_r   <= addr_nxt;
			wdtClr_r <= wdtClr_nxt;
			taken_r  <= taken_nxt;
		end
	end

	// ----------------------------------------------------------------
	// apb registers and interrupt
	// ----------------------------------------------------------------
	logic        rdy_r, rdy_nxt;
	logic        err_r, err_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic        ext_nxt;
	logic [3:0]  bank_nxt;
	logic [soh_pkg::EV_COUNT-1:0] ist_r, ist_nxt;
	logic [soh_pkg::EV_COUNT-1:0] msk_r, msk_nxt;
	logic        irq_r, irq_nxt;
	logic        wrStb;
	logic        hit;

	// decode, read mux and sticky status with set winning over clear
	always_comb
	begin
		ext_nxt  = ext_r;
		bank_nxt = bank_r;
		msk_nxt  = msk_r;
		rdat_nxt = rdat_r;
		err_nxt  = 1'b0;
		wrStb    = psel && penable && rdy_r && pwrite && !err_r;
		hit      = (paddr == soh_pkg::CTRL_OFS) || (paddr == soh_pkg::BANK_OFS) ||
			(paddr == soh_pkg::STATE_OFS) || (paddr == soh_pkg::INTST_OFS) ||
			(paddr == soh_pkg::INTMSK_OFS);
		// answer one cycle into the access phase
		rdy_nxt  = psel && !penable;
		if (psel && !penable)
		begin
			err_nxt  = !hit;
			rdat_nxt = 32'h0000_0000;
			case (paddr)
				soh_pkg::CTRL_OFS:   rdat_nxt[soh_pkg::CTRL_EXT_BIT] = ext_r;
				soh_pkg::BANK_OFS:   rdat_nxt[soh_pkg::BANK_WIDTH-1:0] = bank_r;
				soh_pkg::STATE_OFS:
				begin
					rdat_nxt[soh_pkg::STATE_TMO_BIT]  = tmoFlag_r;
					rdat_nxt[soh_pkg::STATE_PDN_BIT]  = pdnFlag_r;
					rdat_nxt[soh_pkg::STATE_HALT_BIT] = halt_r;
					rdat_nxt[soh_pkg::STATE_PH_LSB +: 2] = phase_r;
				end
				soh_pkg::INTST_OFS:  rdat_nxt[soh_pkg::EV_COUNT-1:0] = ist_r;
				soh_pkg::INTMSK_OFS: rdat_nxt[soh_pkg::EV_COUNT-1:0] = msk_r;
				default:             rdat_nxt = 32'h0000_0000;
			endcase
		end
		ist_nxt = ist_r;
		if (wrStb)
		begin
			case (paddr)
				soh_pkg::CTRL_OFS:   ext_nxt  = pwdata[soh_pkg::CTRL_EXT_BIT];
				soh_pkg::BANK_OFS:   bank_nxt = pwdata[soh_pkg::BANK_WIDTH-1:0];
				soh_pkg::INTST_OFS:  ist_nxt  = ist_r & ~pwdata[soh_pkg::EV_COUNT-1:0];
				soh_pkg::INTMSK_OFS: msk_nxt  = pwdata[soh_pkg::EV_COUNT-1:0];
				default:             ext_nxt  = ext_r;
			endcase
		end
		// new events override a same-cycle clear
		ist_nxt = ist_nxt | evPulse;
		irq_nxt = |(ist_nxt & msk_nxt);
	end

	// registers of the apb side
	always_ff @(posedge clk or negedge rstSync_r)
	begin
		if (!rstSync_r)
		begin
			rdy_r  <= 1'b0;
			err_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
			ext_r  <= soh_pkg::EXT_RESET;
			bank_r <= soh_pkg::BANK_RESET;
			ist_r  <= '0;
			msk_r  <= soh_pkg::MASK_RESET;
			irq_r  <= 1'b0;
		end
		else
		begin
			rdy_r  <= rdy_nxt;
			err_r  <= err_nxt;
			rdat_r <= rdat_nxt;
			ext_r  <= ext_nxt;
			bank_r <= bank_nxt;
			ist_r  <= ist_nxt;
			msk_r  <= msk_nxt;
			irq_r  <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, straight from flops except the constant rfWrData and wdtLoadValue
	// ----------------------------------------------------------------
	assign prdata            = rdat_r;
	assign pready            = rdy_r;
	assign pslverr           = err_r;
	assign instrTaken        = taken_r;
	assign qPhase            = phase_r;
	assign rfRdEn            = rdEn_r;
	assign rfWrEn            = wrEn_r;
	assign rfAddr            = addr_r;
	// constant all-ones write, no status path
	assign rfWrData          = soh_pkg::ALL_ONES;
	assign wdtCntClr         = wdtClr_r;
	assign wdtLoadValue      = soh_pkg::WDT_LOAD;
	assign wdtPostClr        = wdtClr_r;
	assign haltState         = halt_r;
	// oscillator held off for the whole halt
	assign oscStop           = halt_r;
	assign timeout_flag_n    = tmoFlag_r;
	assign power_down_flag_n = pdnFlag_r;
	assign irq               = irq_r;

endmodule
`default_nettype wire

// File: shared/soh_pkg.sv
// constants for the set-all-ones / halt instruction executor
// assumes a core that feeds one 16-bit program word per four-phase cycle
package soh_pkg;

	// ----------------------------------------------------------------
	// instruction encodings
	// ----------------------------------------------------------------
	localparam logic [6:0]  ONES_OPC      = 7'h34;   // upper bits 0110 100
	localparam int          ONES_OPC_LSB  = 9;
	localparam int          ACCESS_BIT    = 8;
	localparam logic [15:0] HALT_OPC      = 16'h0003;
	localparam logic [7:0]  ALL_ONES      = 8'hFF;
	localparam logic [7:0]  WDT_LOAD      = 8'h00;
	localparam logic [7:0]  INDEXED_LIMIT = 8'h5F;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
	localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
	localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] BANK_OFS   = 8'h04;
	localparam logic [7:0] STATE_OFS  = 8'h08;
	localparam logic [7:0] INTST_OFS  = 8'h0C;
	localparam logic [7:0] INTMSK_OFS = 8'h10;

	// field positions
	localparam int CTRL_EXT_BIT   = 0;
	localparam int STATE_TMO_BIT  = 0;
	localparam int STATE_PDN_BIT  = 1;
	localparam int STATE_HALT_BIT = 2;
	localparam int STATE_PH_LSB   = 4;
	localparam int EV_ONES_BIT    = 0;
	localparam int EV_HALT_BIT    = 1;
	localparam int EV_WDTW_BIT    = 2;
	localparam int EV_WAKE_BIT    = 3;
	localparam int EV_COUNT       = 4;
	localparam int BANK_WIDTH     = 4;

	// reset values
	localparam logic       TMO_RESET  = 1'b1;
	localparam logic       PDN_RESET  = 1'b1;
	localparam logic       EXT_RESET  = 1'b0;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// ----------------------------------------------------------------
	// instruction phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} soh_phase_type;

endpackage

// File: shared/soh_dec_if.sv
// carrier between the executor core and its opcode decoder
// assumes both ends share one clock; the decoder is pure logic
`timescale 1ns/10ps
`default_nettype none
interface soh_dec_if;
	logic        instrValid;   // latched word is a real instruction
	logic [15:0] instrWord;
	logic [3:0]  bankSel;
	logic        extEnable;
	logic [11:0] indexBase;
	logic        isOnes;
	logic        isHalt;
	logic [11:0] effAddr;

	modport core (
		output instrValid,
		output instrWord,
		output bankSel,
		output extEnable,
		output indexBase,
		input  isOnes,
		input  isHalt,
		input  effAddr
	);

	modport dec (
		input  instrValid,
		input  instrWord,
		input  bankSel,
		input  extEnable,
		input  indexBase,
		output isOnes,
		output isHalt,
		output effAddr
	);
endinterface
`default_nettype wire

// File: hdl/soh_decode.sv
// opcode decoder and data-memory address former
// assumes the core holds the word stable for the whole cycle
`timescale 1ns/10ps
`default_nettype none
module soh_decode (
	soh_dec_if.dec d
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [7:0] fld;
	logic       accessSel;

	// opcode match and bank/indexed address forming
	always_comb
	begin
		fld       = d.instrWord[7:0];
		accessSel = d.instrWord[soh_pkg::ACCESS_BIT];
		d.isOnes  = d.instrValid &&
			(d.instrWord[15:soh_pkg::ONES_OPC_LSB] == soh_pkg::ONES_OPC);
		// operand-free halt word, every other bit zero
		d.isHalt  = d.instrValid && (d.instrWord == soh_pkg::HALT_OPC);
		if (accessSel)
		begin
			d.effAddr = {d.bankSel, fld};
		end
		else if (d.extEnable && (fld <= soh_pkg::INDEXED_LIMIT))
		begin
			// indexed offset; wraps inside 4K, as the core's adder does
			d.effAddr = d.indexBase + {4'h0, fld};
		end
		else if (fld < soh_pkg::ACCESS_SPLIT)
		begin
			d.effAddr = {soh_pkg::ACCESS_LO_BNK, fld};
		end
		else
		begin
			// access bank, special-function half
			d.effAddr = {soh_pkg::ACCESS_HI_BNK, fld};
		end
	end

endmodule
`default_nettype wire

// File: verif/soh_exec_asserts.sv
// port-level assertions for the set-all-ones / halt executor
// assumes it is bound onto soh_exec; one clock domain
`timescale 1ns/10ps
`default_nettype none
module soh_exec_asserts (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        instrTaken,
	input wire logic [1:0]  qPhase,
	input wire logic        rfRdEn,
	input wire logic        rfWrEn,
	input wire logic [11:0] rfAddr,
	input wire logic [7:0]  rfWrData,
	input wire logic        wdtCntClr,
	input wire logic [7:0]  wdtLoadValue,
	input wire logic        wdtPostClr,
	input wire logic        wdtWake,
	input wire logic        extWake,
	input wire logic        haltState,
	input wire logic        oscStop,
	input wire logic        timeout_flag_n,
	input wire logic        power_down_flag_n
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_wr_ones;
		rfWrEn |-> rfWrData == 8'hFF && $stable(timeout_flag_n) && $stable(power_down_flag_n);
	endproperty
	a_wr_ones: assert property (p_wr_ones) else $error("ones write bad");
	property p_rd_wr;
		rfRdEn |-> qPhase == 2'h1 ##2 (rfWrEn && qPhase == 2'h3 && rfAddr == $past(rfAddr, 2));
	endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("read/write phases bad");
	property p_halt_flags;
		$rose(haltState) |-> !power_down_flag_n && timeout_flag_n;
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags bad");
	property p_wdt_clr;
		$rose(haltState) |-> wdtCntClr && wdtPostClr && wdtLoadValue == 8'h00;
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");
	property p_clr_cause;
		wdtCntClr |-> $rose(haltState);
	endproperty
	a_clr_cause: assert property (p_clr_cause) else $error("stray watchdog clear");
	property p_osc;
		oscStop == haltState;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator stop mismatch");
	property p_halt_hold;
		haltState && !wdtWake && !extWake |=> haltState && qPhase == 2'h3;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
	property p_wdt_wake;
		haltState && wdtWake |=> !haltState && !timeout_flag_n;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake bad");
	property p_ext_wake;
		haltState && extWake && !wdtWake |=> !haltState && timeout_flag_n;
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("external wake bad");
	property p_taken;
		instrTaken |-> qPhase == 2'h0 && $past(qPhase) == 2'h3;
	endproperty
	a_taken: assert property (p_taken) else $error("word taken off phase");
endmodule

bind soh_exec soh_exec_asserts chk (.*);
`default_nettype wire

// File: verif/soh_exec_test.sv
// self-checking bench for the set-all-ones / halt executor
// assumes soh_exec driven straight from its ports; asserts bound aside
`timescale 1ns/10ps
`default_nettype none
module soh_exec_test;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, rfWrData, wdtLoadValue;
	logic [31:0] pwdata, prdata, rd;
	logic        instrValid, instrTaken, rfRdEn, rfWrEn, wdtCntClr, wdtPostClr;
	logic [15:0] instrWord;
	logic [1:0]  qPhase;
	logic [11:0] indexBase, rfAddr;
	logic        wdtWake, extWake, haltState, oscStop, irq;
	logic        timeout_flag_n, power_down_flag_n;
	logic [15:0] junk [3] = '{16'h6A00, 16'h8003, 16'h0013};
	int          badCount = 0;
	int          comparisons = 0;
	int          cycles = 0;

	soh_exec uut (.*);

	// ----------------------------------------------------------------
	// clock, hang guard, helpers
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// generous ceiling; the run needs under two hundred cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			badCount++;
			conclude();
		end
	end

	task automatic conclude();
		if (badCount == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			badCount++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// one apb transfer; no wait count assumed, the hang guard bounds it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// answer taken at the rising edge that sees pready high
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// returns at the edge that opens Q2 of the executing cycle
	task automatic exec(input logic [15:0] w);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
		do @(posedge clk); while (instrTaken !== 1'b1);
		instrValid <= 1'b0;
	endtask

	task automatic setOnes(input logic ext, input logic [3:0] bnk, input logic [11:0] base,
		input logic a, input logic [7:0] f, input logic [11:0] exp);
		apb(1'b1, soh_pkg::CTRL_OFS, {31'h0, ext});
		apb(1'b1, soh_pkg::BANK_OFS, {28'h0, bnk});
		indexBase <= base;
		exec({7'h34, a, f});
		@(negedge clk);
		chkb(rfRdEn, 1'b1);
		chk({20'h0, rfAddr}, {20'h0, exp});
		repeat (2) @(negedge clk);
		chkb(rfWrEn, 1'b1);
		chk({24'h0, rfWrData}, 32'hFF);
	endtask

	// halt, then wake by watchdog or by the external source
	task automatic halt(input logic viaWdt);
		exec(16'h0003);
		repeat (3) @(negedge clk);
		chkb(haltState, 1'b1);
		chkb(oscStop, 1'b1);
		chkb(wdtCntClr & wdtPostClr, 1'b1);
		chk({24'h0, wdtLoadValue}, 32'h0);
		chkb(power_down_flag_n, 1'b0);
		chkb(timeout_flag_n, 1'b1);
		repeat (5) @(negedge clk);
		chkb(haltState, 1'b1);
		@(posedge clk);
		wdtWake <= viaWdt;
		extWake <= !viaWdt;
		@(posedge clk);
		wdtWake <= 1'b0;
		extWake <= 1'b0;
		@(negedge clk);
		chkb(oscStop, 1'b0);
		chkb(timeout_flag_n, !viaWdt);
		chkb(power_down_flag_n, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		instrValid = 1'b0;
		instrWord = 16'h0000;
		indexBase = 12'h000;
		wdtWake = 1'b0;
		extWake = 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(soh_pkg::CTRL_OFS, 32'h0);
		rdchk(soh_pkg::BANK_OFS, 32'h0);
		rdchk(soh_pkg::INTMSK_OFS, 32'h0);
		rdchk(soh_pkg::INTST_OFS, 32'h0);
		apb(1'b0, soh_pkg::STATE_OFS, 32'h0);
		chk(rd & 32'h7, 32'h3);
		// unmapped place refuses both directions
		apb(1'b1, 8'h14, 32'hF);
		chkb(err, 1'b1);
		rdchk(8'h14, 32'h0);
		chkb(err, 1'b1);
		setOnes(1'b0, 4'h5, 12'h000, 1'b1, 8'h3C, 12'h53C);
		setOnes(1'b0, 4'h5, 12'h000, 1'b0, 8'h5F, 12'h05F);
		setOnes(1'b0, 4'h5, 12'h000, 1'b0, 8'h60, 12'hF60);
		setOnes(1'b1, 4'h5, 12'hFF0, 1'b0, 8'h5F, 12'h04F);
		setOnes(1'b1, 4'h5, 12'hFF0, 1'b0, 8'h60, 12'hF60);
		setOnes(1'b1, 4'hA, 12'hFF0, 1'b1, 8'h10, 12'hA10);
		rdchk(soh_pkg::INTST_OFS, 32'h1);
		chkb(irq, 1'b0);
		apb(1'b1, soh_pkg::INTMSK_OFS, 32'h1);
		repeat (2) @(negedge clk);
		chkb(irq, 1'b1);
		apb(1'b1, soh_pkg::INTST_OFS, 32'h1);
		repeat (2) @(negedge clk);
		chkb(irq, 1'b0);
		// near-miss words must do nothing
		foreach (junk[i])
		begin
			exec(junk[i]);
			repeat (3) @(negedge clk);
			chkb(rfWrEn | haltState, 1'b0);
		end
		rdchk(soh_pkg::INTST_OFS, 32'h0);
		halt(1'b1);
		halt(1'b0);
		rdchk(soh_pkg::INTST_OFS, 32'hE);
		apb(1'b1, soh_pkg::INTST_OFS, 32'hF);
		rdchk(soh_pkg::INTST_OFS, 32'h0);
		// mid-run reset: both flags back to their idle level
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, soh_pkg::STATE_OFS, 32'h0);
		chk(rd & 32'h7, 32'h3);
		conclude();
	end
endmodule
`default_nettype wire
